//--- src/timer3_clock_select.sv
// slow clock generation and per-half clock source selection
`timescale 1ns/1ps
`include "timer3_consts.svh"
module timer3_clock_select (
  input  wire logic   clk_sys_i,
  input  wire logic   reset_i,
  input  wire logic   ext_osc_i,
  timer3_tick_if.src  tk
);

  // --------------------------------------------------------------------------
  // external oscillator: synchronise, then divide by 8
  // --------------------------------------------------------------------------
  // oscillator must run below half the system clock or edges are missed
  logic       ext_meta;
  logic       ext_sync;
  logic       ext_prev;
  logic [2:0] ext_div;
  logic [3:0] sys_div;

  wire ext_rise  = ext_sync & ~ext_prev;
  wire ext_tick  = ext_rise & (ext_div == `T3_EXT_RISE_AT);
  wire ext_fall  = ext_rise & (ext_div == `T3_EXT_FALL_AT);
  wire sys_tick  = (sys_div == `T3_SYS_DIV_LAST);
  wire slow_tick = tk.ext_clock_select ? ext_tick : sys_tick;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_prev <= 1'b0;
      ext_div  <= 3'h0;
    end else begin
      ext_meta <= ext_osc_i;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
      if (ext_rise) begin
        ext_div <= ext_div + 3'h1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // system clock divided by 12
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || sys_tick) begin
      sys_div <= 4'h0;
    end else begin
      sys_div <= sys_div + 4'h1;
    end
  end

  // --------------------------------------------------------------------------
  // source per half
  // --------------------------------------------------------------------------
  assign tk.tick_low    = tk.low_half_fast_clock_select | slow_tick;  // [R12] [R13] [R17]
  assign tk.tick_high   = tk.high_half_fast_clock_select | slow_tick; // [R14] [R17]
  assign tk.capture_evt = ext_fall;                                   // [R16]

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  a_fast_every_cycle: assert property ( // [R17]
    tk.low_half_fast_clock_select |-> tk.tick_low)
    else $error("fast low half did not tick");
  a_div12_period: assert property ( // [R12]
    sys_tick |=> !sys_tick [*8] ##1 !sys_tick [*3] ##1 sys_tick)
    else $error("system divide by 12 period wrong");

endmodule : timer3_clock_select

//--- src/timer3_consts.svh
// constants: register indices, field positions, reset values, clock divisions
`ifndef TIMER3_CONSTS_SVH
`define TIMER3_CONSTS_SVH

// ----------------------------------------------------------------------------
// register word indices (byte address = 4 * index)
// ----------------------------------------------------------------------------
`define T3_IDX_CONTROL    10'h091
`define T3_IDX_RELOAD_LO  10'h092
`define T3_IDX_RELOAD_HI  10'h093
`define T3_IDX_COUNT_LO   10'h094
`define T3_IDX_COUNT_HI   10'h095
`define T3_IDX_CLOCK_CTL  10'h096

// ----------------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------------
`define T3_BIT_FLAG_H     7
`define T3_BIT_FLAG_L     6
`define T3_BIT_LOW_IRQ_EN 5
`define T3_BIT_CAPTURE_EN 4
`define T3_BIT_SPLIT      3
`define T3_BIT_RUN        2
`define T3_BIT_UNUSED     1
`define T3_BIT_EXT_SEL    0
`define T3_CONTROL_RESET  8'h00

// ----------------------------------------------------------------------------
// clock control register fields
// ----------------------------------------------------------------------------
`define T3_BIT_FAST_LO    0
`define T3_BIT_FAST_HI    1
`define T3_BIT_IRQ_EN     2
`define T3_CLOCK_RESET    8'h00

// ----------------------------------------------------------------------------
// clock division
// ----------------------------------------------------------------------------
`define T3_SYS_DIV        12
`define T3_SYS_DIV_LAST   4'hb
`define T3_EXT_DIV        8
`define T3_EXT_RISE_AT    3'h3
`define T3_EXT_FALL_AT    3'h7
`define T3_BYTE_MAX       8'hff
`define T3_COUNT_RESET    8'h00

`endif

//--- src/timer3_control_capture.sv
// timer three: control, counting, reload, capture and wishbone registers
//
// Overview of operation
// R1 - high flag sets on high byte wrap
// R2 - 16-bit mode: high flag on full wrap
// R3 - enabled high flag requests interrupt
// R4 - flags cleared only by software
// R5 - low flag sets on low byte wrap
// R6 - low flag interrupts when its enable set
// R7 - capture enable bit switches capture mode
// R8 - split bit: one 16-bit or two 8-bit
// R9 - run bit gates 16-bit counting
// R10 - split: run gates high only
// R11 - control bit 1 reads zero, ignores writes
// R12 - ext select 0: system clock / 12
// R13 - ext select 1: synced external / 8
// R14 - split: ext select for both halves
// R15 - overflow reloads count from reload registers
// R16 - capture copies count, sets high flag
// R17 - fast select picks system clock per half
// R18 - software keeps capture in 16-bit, fast clock
// R19 - interrupt level from enables and flags
// R20 - hardware set beats software clear
`timescale 1ns/1ps
`include "timer3_consts.svh"
module timer3_control_capture (
  input  wire logic        clk_sys_i,
  input  wire logic        reset_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic        ext_osc_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq_o
);

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  logic            high_overflow_flag;
  logic            low_overflow_flag;
  logic            low_byte_irq_enable;
  logic            capture_enable;
  logic            split_mode;
  logic            run_control;
  logic            ext_clock_select;
  logic            high_half_fast_clock_select;
  logic            low_half_fast_clock_select;
  logic            irq_enable;
  timer3_pkg::byte_t count_low;
  timer3_pkg::byte_t count_high;
  timer3_pkg::byte_t reload_low;
  timer3_pkg::byte_t reload_high;
  timer3_pkg::byte_t next_count_low;
  timer3_pkg::byte_t next_count_high;

  timer3_tick_if tk ();

  assign tk.ext_clock_select            = ext_clock_select;
  assign tk.low_half_fast_clock_select  = low_half_fast_clock_select;
  assign tk.high_half_fast_clock_select = high_half_fast_clock_select;

  timer3_clock_select u_clock_select (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .ext_osc_i (ext_osc_i),
    .tk        (tk.src)
  );

  // --------------------------------------------------------------------------
  // bus decode
  // --------------------------------------------------------------------------
  wire [9:0]         word_idx  = wb_adr_i[11:2];
  wire               bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // a write lands at the ack edge, where the master completes the cycle
  wire               bus_wr    = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
  wire timer3_pkg::byte_t wbyte = wb_dat_i[7:0];

  wire hit_ctrl   = (word_idx == `T3_IDX_CONTROL);
  wire hit_rld_lo = (word_idx == `T3_IDX_RELOAD_LO);
  wire hit_rld_hi = (word_idx == `T3_IDX_RELOAD_HI);
  wire hit_cnt_lo = (word_idx == `T3_IDX_COUNT_LO);
  wire hit_cnt_hi = (word_idx == `T3_IDX_COUNT_HI);
  wire hit_clk    = (word_idx == `T3_IDX_CLOCK_CTL);

  wire wr_ctrl    = bus_wr & hit_ctrl;
  wire wr_rld_lo  = bus_wr & hit_rld_lo;
  wire wr_rld_hi  = bus_wr & hit_rld_hi;
  wire wr_cnt_lo  = bus_wr & hit_cnt_lo;
  wire wr_cnt_hi  = bus_wr & hit_cnt_hi;
  wire wr_clk     = bus_wr & hit_clk;

  // bit 1 is never stored, so it always reads zero
  wire timer3_pkg::byte_t ctrl_rd = {high_overflow_flag, low_overflow_flag,
                                     low_byte_irq_enable, capture_enable,
                                     split_mode, run_control, 1'b0,
                                     ext_clock_select}; // [R11]
  wire timer3_pkg::byte_t clk_rd  = {5'h00, irq_enable, high_half_fast_clock_select,
                                     low_half_fast_clock_select};

  // unmapped words answer with zero
  wire timer3_pkg::byte_t rd_byte =
    hit_ctrl   ? ctrl_rd     :
    hit_rld_lo ? reload_low  :
    hit_rld_hi ? reload_high :
    hit_cnt_lo ? count_low   :
    hit_cnt_hi ? count_high  :
    hit_clk    ? clk_rd      : 8'h00;

  // --------------------------------------------------------------------------
  // count events
  // --------------------------------------------------------------------------
  // 16-bit mode steps on the low half's source
  wire tick16      = ~split_mode & run_control & tk.tick_low;                  // [R8] [R9]
  wire low_full    = (count_low == `T3_BYTE_MAX);
  wire high_full   = (count_high == `T3_BYTE_MAX);
  wire wrap16      = tick16 & low_full & high_full;                           // [R2]
  wire carry16     = tick16 & low_full;
  wire tick_lo8    = split_mode & tk.tick_low;                                // [R10]
  wire tick_hi8    = split_mode & run_control & tk.tick_high;                 // [R10]
  wire wrap_lo8    = tick_lo8 & low_full;
  wire wrap_hi8    = tick_hi8 & high_full;                                    // [R1]
  // capture in split mode is allowed but meaningless to software
  wire capture     = capture_enable & tk.capture_evt;                         // [R7] [R18]
  wire set_high    = wrap16 | wrap_hi8 | capture;                             // [R1] [R16]
  wire set_low     = carry16 | wrap_lo8;                                      // [R5]
  wire irq_level   = irq_enable & (high_overflow_flag |
                                   (low_overflow_flag & low_byte_irq_enable)); // [R3] [R6] [R19]

  always_comb begin
    next_count_low  = count_low;
    next_count_high = count_high;
    if (tick16) begin
      if (wrap16) begin
        next_count_low  = reload_low;                                         // [R15]
        next_count_high = reload_high;
      end else begin
        next_count_low  = count_low + 8'h01;
        next_count_high = low_full ? count_high + 8'h01 : count_high;
      end
    end
    if (tick_lo8) begin
      next_count_low = wrap_lo8 ? reload_low : count_low + 8'h01;            // [R15]
    end
    if (tick_hi8) begin
      next_count_high = wrap_hi8 ? reload_high : count_high + 8'h01;         // [R15]
    end
    // a software write to the count overrides a tick in the same cycle
    if (wr_cnt_lo) begin
      next_count_low = wbyte;
    end
    if (wr_cnt_hi) begin
      next_count_high = wbyte;
    end
  end

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      count_low  <= `T3_COUNT_RESET;
      count_high <= `T3_COUNT_RESET;
    end else begin
      count_low  <= next_count_low;
      count_high <= next_count_high;
    end
  end

  // capture wins over a software write to the reload bytes
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      reload_low  <= `T3_COUNT_RESET;
      reload_high <= `T3_COUNT_RESET;
    end else if (capture) begin
      reload_low  <= count_low;                                               // [R16]
      reload_high <= count_high;
    end else begin
      reload_low  <= wr_rld_lo ? wbyte : reload_low;
      reload_high <= wr_rld_hi ? wbyte : reload_high;
    end
  end

  // flags: only a write can clear, and a set in the same cycle wins
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      high_overflow_flag <= 1'b0;
      low_overflow_flag  <= 1'b0;
    end else begin
      high_overflow_flag <= set_high |
        (wr_ctrl ? wbyte[`T3_BIT_FLAG_H] : high_overflow_flag);              // [R4] [R20]
      low_overflow_flag  <= set_low |
        (wr_ctrl ? wbyte[`T3_BIT_FLAG_L] : low_overflow_flag);               // [R4] [R20]
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      low_byte_irq_enable <= 1'b0;
      capture_enable      <= 1'b0;
      split_mode          <= 1'b0;
      run_control         <= 1'b0;
      ext_clock_select    <= 1'b0;
    end else if (wr_ctrl) begin
      low_byte_irq_enable <= wbyte[`T3_BIT_LOW_IRQ_EN];                      // [R6]
      capture_enable      <= wbyte[`T3_BIT_CAPTURE_EN];                      // [R7]
      split_mode          <= wbyte[`T3_BIT_SPLIT];                           // [R8]
      run_control         <= wbyte[`T3_BIT_RUN];                             // [R9]
      ext_clock_select    <= wbyte[`T3_BIT_EXT_SEL];                         // [R12] [R13]
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      low_half_fast_clock_select  <= 1'b0;
      high_half_fast_clock_select <= 1'b0;
      irq_enable                  <= 1'b0;
    end else if (wr_clk) begin
      low_half_fast_clock_select  <= wbyte[`T3_BIT_FAST_LO];                 // [R17]
      high_half_fast_clock_select <= wbyte[`T3_BIT_FAST_HI];                 // [R17]
      irq_enable                  <= wbyte[`T3_BIT_IRQ_EN];
    end
  end

  // --------------------------------------------------------------------------
  // bus answer and interrupt output
  // --------------------------------------------------------------------------
  // every access, mapped or not, is answered one cycle after it is seen
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      irq_o    <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      irq_o    <= irq_level;                                                  // [R3] [R19]
    end
  end

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  wire cnt_wr = wr_cnt_lo | wr_cnt_hi;

  a_full_wrap_reload: assert property ( // [R2] [R15]
    (wrap16 && !cnt_wr) |=> ({count_high, count_low} == $past({reload_high, reload_low}))
                            && high_overflow_flag && low_overflow_flag)
    else $error("16-bit wrap did not reload or flag");

  a_high_byte_wrap: assert property ( // [R1]
    (split_mode && run_control && tk.tick_high && high_full && !cnt_wr)
      |=> high_overflow_flag && (count_high == $past(reload_high)))
    else $error("high byte wrap missed");

  a_low_byte_wrap: assert property ( // [R5]
    (tk.tick_low && low_full && (split_mode || run_control)) |=> low_overflow_flag)
    else $error("low byte wrap did not set low flag");

  a_flags_sticky: assert property ( // [R4]
    (high_overflow_flag && !wr_ctrl)
      |=> high_overflow_flag)
    else $error("high flag cleared without a write");

  a_set_beats_clear: assert property ( // [R20]
    (set_low && wr_ctrl && !wbyte[`T3_BIT_FLAG_L]) |=> low_overflow_flag)
    else $error("software clear beat a hardware set");

  a_unused_zero: assert property ( // [R11]
    (wb_ack_o && $past(hit_ctrl)) |-> (wb_dat_o[`T3_BIT_UNUSED] == 1'b0))
    else $error("unused control bit read as one");

  a_stopped_holds: assert property ( // [R9]
    (!split_mode && !run_control && !cnt_wr) |=> $stable({count_high, count_low}))
    else $error("16-bit count moved while stopped");

  a_split_low_runs: assert property ( // [R10]
    (split_mode && !run_control && tk.tick_low && !low_full && !cnt_wr)
      |=> (count_low == $past(count_low) + 8'h01) && $stable(count_high))
    else $error("split low half not free running");

  a_capture_copies: assert property ( // [R16]
    capture |=> ({reload_high, reload_low} == $past({count_high, count_low}))
                && high_overflow_flag)
    else $error("capture did not copy count");

  a_irq_follows: assert property ( // [R3] [R6] [R19]
    irq_enable && low_byte_irq_enable && low_overflow_flag && $stable(irq_enable)
      |=> irq_o)
    else $error("interrupt not raised for low flag");

  c_capture_seen:  cover property (capture ##2 irq_o);
  c_split_low_wrap: cover property (split_mode && wrap_lo8);
  c_full_wrap:     cover property (wrap16 ##[1:20] wb_ack_o);

endmodule : timer3_control_capture

//--- src/timer3_pkg.sv
// types shared by the timer blocks
package timer3_pkg;

  typedef logic [7:0]  byte_t;
  typedef logic [15:0] count_t;

  typedef enum logic [2:0] {
    SRC_SYS_DIV12 = 3'h1,
    SRC_EXT_DIV8  = 3'h2,
    SRC_SYS_FAST  = 3'h4
  } clock_source_t;

endpackage : timer3_pkg

//--- src/timer3_tick_if.sv
// count ticks and capture events handed from clock selection to the timer
`timescale 1ns/1ps
interface timer3_tick_if;
  logic ext_clock_select;
  logic low_half_fast_clock_select;
  logic high_half_fast_clock_select;
  logic tick_low;
  logic tick_high;
  logic capture_evt;

  modport src (
    input  ext_clock_select,
    input  low_half_fast_clock_select,
    input  high_half_fast_clock_select,
    output tick_low,
    output tick_high,
    output capture_evt
  );

  modport sink (
    output ext_clock_select,
    output low_half_fast_clock_select,
    output high_half_fast_clock_select,
    input  tick_low,
    input  tick_high,
    input  capture_evt
  );
endinterface : timer3_tick_if

//--- tb/timer3_control_capture_bench.sv
// self-checking bench for the timer three control and capture block
`timescale 1ns/1ps
`include "timer3_consts.svh"
module timer3_control_capture_bench;
  logic        clk_sys_i;
  logic        reset_i;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [11:0] wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic        ext_osc_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        irq_o;
  int          errors;
  int          checks_done;
  int          cycles;
  logic [7:0]  q;
  logic [7:0]  r;

  timer3_control_capture dut (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .wb_cyc_i  (wb_cyc_i),
    .wb_stb_i  (wb_stb_i),
    .wb_we_i   (wb_we_i),
    .wb_adr_i  (wb_adr_i),
    .wb_sel_i  (wb_sel_i),
    .wb_dat_i  (wb_dat_i),
    .ext_osc_i (ext_osc_i),
    .wb_dat_o  (wb_dat_o),
    .wb_ack_o  (wb_ack_o),
    .irq_o     (irq_o)
  );

  // ---------------------------------------------------------------------------
  // clock, timeout and closing
  // ---------------------------------------------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  // whole run needs well under 10000 cycles
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // ---------------------------------------------------------------------------
  // classic wishbone single cycle; samples are pre-edge values
  // ---------------------------------------------------------------------------
  task automatic wb(input logic we, input logic [9:0] idx, input logic [7:0] d,
                    output logic [7:0] rdata);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h000000, d};
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors = errors + 1;
      $display("no acknowledge at %0t", $time);
    end
    rdata = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask : wb

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic [7:0] dummy;
    wb(1'b1, idx, d, dummy);
  endtask : wr

  task automatic rd(input logic [9:0] idx, output logic [7:0] v);
    wb(1'b0, idx, 8'h00, v);
  endtask : rd

  // one pin period is 8 system clocks, well below half the system rate
  task automatic osc_edges(input int n);
    repeat (n) begin
      @(posedge clk_sys_i);
      ext_osc_i <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      ext_osc_i <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
    end
  endtask : osc_edges

  task automatic wait_irq(input int limit);
    int n;
    n = 0;
    while (irq_o !== 1'b1 && n < limit) begin
      @(posedge clk_sys_i);
      n++;
    end
  endtask : wait_irq

  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task automatic test_reset_map();
    for (int i = 0; i < 6; i++) begin
      rd(`T3_IDX_CONTROL + 10'(i), q);
      check(q, 8'h00);
    end
    rd(10'h0a0, q);
    check(q, 8'h00);
    check(irq_o, 1'b0);
    wr(`T3_IDX_CONTROL, 8'h02);
    rd(`T3_IDX_CONTROL, q);
    check(q, 8'h00);
    wr(10'h0a0, 8'hff);
    rd(10'h0a0, q);
    check(q, 8'h00);
    $display("test reset_map done");
  endtask : test_reset_map

  task automatic test_wrap16();
    wr(`T3_IDX_CLOCK_CTL, 8'h05);
    wr(`T3_IDX_RELOAD_LO, 8'h34);
    wr(`T3_IDX_RELOAD_HI, 8'h12);
    wr(`T3_IDX_COUNT_LO, 8'hfd);
    wr(`T3_IDX_COUNT_HI, 8'hff);
    wr(`T3_IDX_CONTROL, 8'h04);
    wait_irq(50);
    check(irq_o, 1'b1);
    // writing ones keeps both flags while run goes off
    wr(`T3_IDX_CONTROL, 8'hc0);
    rd(`T3_IDX_CONTROL, q);
    check(q, 8'hc0);
    rd(`T3_IDX_COUNT_HI, q);
    check(q, 8'h12);
    rd(`T3_IDX_COUNT_LO, q);
    repeat (40) @(posedge clk_sys_i);
    rd(`T3_IDX_COUNT_LO, r);
    check(r, q);
    repeat (100) @(posedge clk_sys_i);
    rd(`T3_IDX_CONTROL, q);
    check(q, 8'hc0);
    wr(`T3_IDX_CONTROL, 8'h00);
    rd(`T3_IDX_CONTROL, q);
    check(q, 8'h00);
    check(irq_o, 1'b0);
    $display("test wrap16 done");
  endtask : test_wrap16

  task automatic test_split();
    wr(`T3_IDX_CLOCK_CTL, 8'h07);
    wr(`T3_IDX_RELOAD_LO, 8'h80);
    wr(`T3_IDX_RELOAD_HI, 8'h40);
    wr(`T3_IDX_COUNT_LO, 8'hf0);
    wr(`T3_IDX_COUNT_HI, 8'h00);
    wr(`T3_IDX_CONTROL, 8'h08);
    repeat (300) @(posedge clk_sys_i);
    rd(`T3_IDX_CONTROL, q);
    check(q, 8'h48);
    rd(`T3_IDX_COUNT_HI, q);
    check(q, 8'h00);
    rd(`T3_IDX_COUNT_LO, q);
    check(q >= 8'h80, 1'b1);
    check(irq_o, 1'b0);
    wr(`T3_IDX_CONTROL, 8'h4c);
    repeat (300) @(posedge clk_sys_i);
    rd(`T3_IDX_CONTROL, q);
    check(q, 8'hcc);
    check(irq_o, 1'b1);
    // keeps the next low wrap far from the clear below
    wr(`T3_IDX_COUNT_LO, 8'h80);
    wr(`T3_IDX_CONTROL, 8'h28);
    repeat (3) @(posedge clk_sys_i);
    check(irq_o, 1'b0);
    wait_irq(200);
    check(irq_o, 1'b1);
    wr(`T3_IDX_CONTROL, 8'h00);
    $display("test split done");
  endtask : test_split

  task automatic test_sources();
    wr(`T3_IDX_CLOCK_CTL, 8'h00);
    wr(`T3_IDX_COUNT_LO, 8'h00);
    wr(`T3_IDX_COUNT_HI, 8'h00);
    wr(`T3_IDX_CONTROL, 8'h04);
    repeat (240) @(posedge clk_sys_i);
    wr(`T3_IDX_CONTROL, 8'h00);
    rd(`T3_IDX_COUNT_LO, q);
    // prescaler phase is free running, so allow one tick either way
    check(q >= 8'd19 && q <= 8'd21, 1'b1);
    wr(`T3_IDX_COUNT_LO, 8'h00);
    wr(`T3_IDX_CONTROL, 8'h05);
    osc_edges(16);
    repeat (10) @(posedge clk_sys_i);
    wr(`T3_IDX_CONTROL, 8'h00);
    rd(`T3_IDX_COUNT_LO, q);
    check(q, 8'h02);
    $display("test sources done");
  endtask : test_sources

  // pin edge count stays a multiple of 8 so capture lands on the last edge
  task automatic test_capture();
    wr(`T3_IDX_CLOCK_CTL, 8'h05);
    wr(`T3_IDX_RELOAD_LO, 8'h00);
    wr(`T3_IDX_RELOAD_HI, 8'h00);
    wr(`T3_IDX_COUNT_LO, 8'h00);
    wr(`T3_IDX_COUNT_HI, 8'h00);
    wr(`T3_IDX_CONTROL, 8'h04);
    osc_edges(8);
    repeat (8) @(posedge clk_sys_i);
    rd(`T3_IDX_CONTROL, q);
    check(q & 8'h80, 8'h00);
    rd(`T3_IDX_RELOAD_HI, q);
    check(q, 8'h00);
    wr(`T3_IDX_CONTROL, 8'h14);
    osc_edges(8);
    repeat (8) @(posedge clk_sys_i);
    rd(`T3_IDX_CONTROL, q);
    check(q & 8'h80, 8'h80);
    rd(`T3_IDX_RELOAD_LO, q);
    rd(`T3_IDX_RELOAD_HI, r);
    check({r, q} != 16'h0000, 1'b1);
    wr(`T3_IDX_CONTROL, 8'h00);
    $display("test capture done");
  endtask : test_capture

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    errors      = 0;
    checks_done = 0;
    cycles      = 0;
    reset_i     = 1'b1;
    wb_cyc_i    = 1'b0;
    wb_stb_i    = 1'b0;
    wb_we_i     = 1'b0;
    wb_adr_i    = 12'h000;
    wb_sel_i    = 4'h0;
    wb_dat_i    = 32'h00000000;
    ext_osc_i   = 1'b0;
    repeat (6) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    @(posedge clk_sys_i);
    test_reset_map();
    test_wrap16();
    test_split();
    test_sources();
    test_capture();
    report_and_stop();
  end
endmodule : timer3_control_capture_bench
